// [bepc_pkg.sv]
// Purpose: Shared constants for the boost envelope PWM controller
// Assumes: 100 MHz pclk, 48 kHz audio sample strobe
// Notes:   Register offsets are byte addresses on APB
package bepc_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned FS_HZ       = 48_000;
  localparam int unsigned RATE8_HZ    = 384_000;    // 8-step repetition rate
  localparam int unsigned RATE16_HZ   = 192_000;    // 16-step repetition rate
  localparam int unsigned LOOK_MAX_US = 4_000;      // Longest look-ahead
  localparam int unsigned HOLD_MAX_US = 8_000;      // Longest peak hold
  // Cycles per quantisation step, rounded down; both formats share it
  localparam int unsigned STEP_CYC    = CLK_HZ / (RATE8_HZ * 8);
  localparam int unsigned DLY_DEPTH   = FS_HZ / 1000 * LOOK_MAX_US / 1000;
  localparam int unsigned HOLD_MAX    = FS_HZ / 1000 * HOLD_MAX_US / 1000;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_DELAY   = 8'h04;
  localparam logic [7:0] ADDR_HOLD    = 8'h08;
  localparam logic [7:0] ADDR_TRIM    = 8'h0c;
  localparam logic [7:0] ADDR_STAT    = 8'h10;
  localparam int unsigned CTRL_EN     = 0;          // Controller enable
  localparam int unsigned CTRL_FMT    = 1;          // 1 = 16 steps, 192 kHz
  localparam int unsigned CTRL_OD     = 6;          // 1 = open-drain drive
  localparam logic [7:0] CTRL_RST     = 8'h40;
  localparam logic [7:0] DELAY_RST    = 8'h00;
  localparam logic [8:0] HOLD_RST     = 9'h000;
  localparam logic [7:0] TRIM_RST     = 8'h00;
endpackage

// [bepc_top.sv]
// Purpose: Envelope-tracking PWM control of an external boost converter
// Assumes: Audio arrives as signed 16-bit words with a one-cycle strobe
// Notes:   Pin is split into level, enable; the bench resolves the wire
// Operation
// R1 - Eight steps 384 kHz or sixteen 192 kHz
// R2 - Look-ahead audio delay up to 4 ms; code clamps at 191 samples, just under 4 ms
// R3 - Hold detected peak up to 8 ms
// R4 - Auto step levels with software trim
// R5 - Duty proportional to peak when enabled
// R6 - Open-drain low-only drive by default
// R7 - Bit 6 low gives push-pull drive
// R8 - Software clears bit 6 for single device
// R9 - Multi-device systems keep open-drain drive
// R10 - Software programs tracking via pages five, six
// R11 - Duty held one full period minimum
//
// Local design decisions: the APB register port and the placing of the registers.
module bepc_top import bepc_pkg::*; (
  input  wire logic        pclk,         // 100 MHz clock
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB write
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped address
  input  wire logic [15:0] audio_i,      // Signed audio sample
  input  wire logic        audio_vld_i,  // Sample strobe
  output logic      [15:0] audio_o,      // Delayed audio sample
  output logic             audio_vld_o,  // Delayed sample strobe
  output logic             pwm_o,        // Control pin level
  output logic             pwm_oe        // Control pin drive enable
);
  localparam logic [7:0] STEPC = 8'(STEP_CYC);

  // Magnitude of a signed sample, saturating at full scale
  function automatic logic [14:0] mag(input logic [15:0] s);
    logic [15:0] n;
    n = s[15] ? 16'(-s) : s;
    return n[15] ? 15'h7fff : n[14:0];
  endfunction

  // Register file and APB slave
  logic [7:0]  ctrl_r, ctrl_nxt, dly_r, dly_nxt, trim_r, trim_nxt;
  logic [8:0]  hold_r, hold_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt, pslverr_nxt, hit;
  logic [3:0]  level_r, level_nxt;
  logic [14:0] peak_r, peak_nxt;

  always_comb begin
    ctrl_nxt    = ctrl_r;
    dly_nxt     = dly_r;
    hold_nxt    = hold_r;
    trim_nxt    = trim_r;
    prdata_nxt  = prdata;
    hit         = 1'b1;
    case (paddr)
      ADDR_CTRL, ADDR_DELAY, ADDR_HOLD, ADDR_TRIM, ADDR_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    pready_nxt  = psel && !penable;             // Answer in the access cycle
    pslverr_nxt = psel && !penable && !hit;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL:  prdata_nxt = {24'h000000, ctrl_r};
        ADDR_DELAY: prdata_nxt = {24'h000000, dly_r};
        ADDR_HOLD:  prdata_nxt = {23'h000000, hold_r};
        ADDR_TRIM:  prdata_nxt = {24'h000000, trim_r};
        ADDR_STAT:  prdata_nxt = {11'h000, pwm_o, level_r, 1'b0, peak_r};
        default:    prdata_nxt = 32'h00000000;
      endcase
    end
    if (psel && penable && pready && pwrite) begin
      case (paddr)
        ADDR_CTRL:  ctrl_nxt = {1'b0, pwdata[6], 4'h0, pwdata[1:0]}; // [R7] [R9]
        ADDR_DELAY: dly_nxt  = (pwdata[7:0] >= 8'(DLY_DEPTH)) ?
                               8'(DLY_DEPTH - 1) : pwdata[7:0];       // [R2]
        ADDR_HOLD:  hold_nxt = (pwdata[8:0] > 9'(HOLD_MAX)) ?
                               9'(HOLD_MAX) : pwdata[8:0];           // [R3]
        ADDR_TRIM:  trim_nxt = pwdata[7:0];                           // [R4]
        default:    ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= CTRL_RST;                                            // [R6]
      dly_r   <= DELAY_RST;
      hold_r  <= HOLD_RST;
      trim_r  <= TRIM_RST;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      dly_r   <= dly_nxt;
      hold_r  <= hold_nxt;
      trim_r  <= trim_nxt;
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // Look-ahead delay line and peak hold; detection sees audio early
  logic [15:0] dmem [DLY_DEPTH];
  logic [7:0]  wp_r, wp_nxt, rp;
  logic [8:0]  hcnt_r, hcnt_nxt;
  logic [14:0] m;

  always_comb begin
    wp_nxt   = wp_r;
    peak_nxt = peak_r;
    hcnt_nxt = hcnt_r;
    m        = mag(audio_i);
    rp       = (wp_r >= dly_r) ? 8'(wp_r - dly_r) : 8'(wp_r + 8'(DLY_DEPTH) - dly_r);
    if (audio_vld_i) begin
      wp_nxt = (wp_r == 8'(DLY_DEPTH - 1)) ? 8'h00 : 8'(wp_r + 8'h01);  // [R2]
      if (m >= peak_r) begin
        peak_nxt = m;
        hcnt_nxt = hold_r;
      end else if (hcnt_r != 9'h000) begin
        hcnt_nxt = 9'(hcnt_r - 9'h001);                               // [R3]
      end else begin
        peak_nxt = 15'(peak_r - (peak_r >> 4));                       // Slow release
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r        <= 8'h00;
      peak_r      <= 15'h0000;
      hcnt_r      <= 9'h000;
      audio_o     <= 16'h0000;
      audio_vld_o <= 1'b0;
    end else begin
      wp_r        <= wp_nxt;
      peak_r      <= peak_nxt;
      hcnt_r      <= hcnt_nxt;
      audio_vld_o <= audio_vld_i;
      if (audio_vld_i) begin
        audio_o <= (dly_r == 8'h00) ? audio_i : dmem[rp];             // [R2]
      end
    end
  end

  // Delay storage; written once per sample after the old word is read
  always_ff @(posedge pclk) begin
    if (audio_vld_i) begin
      dmem[wp_r] <= audio_i;
    end
  end

  // PWM engine; duty taken only at the start of each period
  logic [7:0]  scnt_r, scnt_nxt;
  logic [3:0]  slot_r, slot_nxt, lvl_q;
  logic [15:0] adj;
  logic        pwm_nxt, oe_nxt, hi;

  always_comb begin
    // Trim biases the automatic step thresholds, saturating
    adj       = {1'b0, peak_r} + {trim_r, 7'h00};                     // [R4]
    if (adj[15]) adj = 16'h7fff;
    lvl_q     = ctrl_r[CTRL_FMT] ? adj[14:11] : {1'b0, adj[14:12]};   // [R11]
    scnt_nxt  = (scnt_r == STEPC - 8'h01) ? 8'h00 : 8'(scnt_r + 8'h01);
    slot_nxt  = slot_r;
    level_nxt = level_r;
    if (scnt_r == STEPC - 8'h01) begin
      slot_nxt = ((!ctrl_r[CTRL_FMT] && slot_r == 4'h7) || slot_r == 4'hf) ?
                 4'h0 : 4'(slot_r + 4'h1);                            // [R1]
      if (slot_nxt == 4'h0) level_nxt = lvl_q;                        // [R11]
    end
    hi      = ctrl_r[CTRL_EN] && (slot_nxt < level_nxt);              // [R5]
    // Drive mode follows the incoming setting, so a switch to open-drain
    // never leaves one high cycle on a wire shared with other devices
    pwm_nxt = ctrl_nxt[CTRL_OD] ? 1'b0 : hi;                          // [R9]
    oe_nxt  = ctrl_nxt[CTRL_OD] ? !hi : 1'b1;                         // [R6] [R7]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt_r  <= 8'h00;
      slot_r  <= 4'h0;
      level_r <= 4'h0;
      pwm_o   <= 1'b0;
      pwm_oe  <= 1'b1;          // Open-drain idle low until enabled
    end else begin
      scnt_r  <= scnt_nxt;
      slot_r  <= slot_nxt;
      level_r <= level_nxt;
      pwm_o   <= pwm_nxt;
      pwm_oe  <= oe_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_od_never_high;
    ctrl_r[CTRL_OD] |-> !pwm_o;
  endproperty
  a_od_never_high: assert property (p_od_never_high) else $error("open-drain drove high"); // [R6]
  property p_pp_drives;
    !ctrl_r[CTRL_OD] |-> pwm_oe;
  endproperty
  a_pp_drives: assert property (p_pp_drives) else $error("push-pull released pin"); // [R7]
  property p_level_stable;
    !(slot_r == 4'h0 && scnt_r == 8'h00) |-> $stable(level_r);
  endproperty
  a_level_stable: assert property (p_level_stable) else $error("duty changed mid period"); // [R11]
  property p_slot_wrap8;
    !ctrl_r[CTRL_FMT] && slot_r == 4'h7 && scnt_r == STEPC - 8'h01 |=> slot_r == 4'h0;
  endproperty
  a_slot_wrap8: assert property (p_slot_wrap8) else $error("8-step slot overrun"); // [R1]
  sequence s_step_end;
    scnt_r == STEPC - 8'h01;
  endsequence
  property p_step_len;
    s_step_end |=> scnt_r == 8'h00 ##1 scnt_r == 8'h01;
  endproperty
  a_step_len: assert property (p_step_len) else $error("step counter wrong"); // [R1]
  property p_off_no_pulse;
    !ctrl_r[CTRL_EN] ##1 !ctrl_r[CTRL_EN] |-> !pwm_o && pwm_oe;
  endproperty
  a_off_no_pulse: assert property (p_off_no_pulse) else $error("pulse while disabled"); // [R5]
  property p_hold_peak;
    audio_vld_i && hcnt_r != 9'h000 && mag(audio_i) < peak_r |=> $stable(peak_r);
  endproperty
  a_hold_peak: assert property (p_hold_peak) else $error("peak fell during hold"); // [R3]
  property p_dly_range;
    dly_r < 8'(DLY_DEPTH) && hold_r <= 9'(HOLD_MAX);
  endproperty
  a_dly_range: assert property (p_dly_range) else $error("delay or hold beyond limit"); // [R2]
  property p_apb_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("ready not one cycle"); // Local APB port decision
endmodule

// [bepc_boost_model.sv]
// Purpose: Boost converter feedback side, the shared control wire
// Assumes: One pull-up on the wire, RC filter seen as a high counter
// Notes:   Counter clears on clr and sums high wire samples
module bepc_boost_model (
  input  wire logic       pclk,    // Bench clock
  input  wire logic       pwm_o,   // Pin level from device
  input  wire logic       pwm_oe,  // Pin drive enable
  input  wire logic       clr,     // Restart measurement
  output logic            pin,     // Resolved wire level
  output logic [9:0]      hi_cnt,  // High samples since clr
  output logic [9:0]      drv_hi   // Samples driven high by device
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins only while nobody drives; shared wire of open drains
  assign pin = pwm_oe ? pwm_o : 1'b1;
  // Filter stand-in: a high count over a whole period is the duty
  always @(posedge pclk) begin
    hi_cnt <= clr ? 10'h000 : hi_cnt + {9'h000, pin};
    drv_hi <= clr ? 10'h000 : drv_hi + {9'h000, pwm_oe & pwm_o};
  end
endmodule

// [test_boost_envelope_pwm_ctrl.sv]
// Purpose: Self-checking bench for the envelope PWM controller
// Assumes: Wait-free APB slave, step of 32 cycles, audio held silent for PWM
// Notes:   Register cases in a table, duty and delay cases after it
module test_boost_envelope_pwm_ctrl;
  import bepc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} bepc_row_t;
  typedef struct {logic [7:0] ctl; logic [7:0] trim; int per; logic [9:0] hi;} bepc_pwm_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, audio_vld_i = 0, clr = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] audio_i = 16'h0000, audio_o;
  logic pready, pslverr, audio_vld_o, pwm_o, pwm_oe, pin, er;
  logic [9:0] hi_cnt, drv_hi;
  int err_total = 0, checks = 0;
  bepc_row_t rows [9] = '{
    '{0, ADDR_CTRL, 0, 32'h40, 0}, '{0, ADDR_DELAY, 0, 0, 0}, '{0, ADDR_HOLD, 0, 0, 0},
    '{0, ADDR_TRIM, 0, 0, 0}, '{1, ADDR_DELAY, 32'hff, 0, 0}, '{0, ADDR_DELAY, 0, 32'hbf, 0},
    '{1, ADDR_HOLD, 32'h1ff, 0, 0}, '{0, ADDR_HOLD, 0, 32'h180, 0}, '{0, 8'h14, 0, 0, 1}};
  bepc_pwm_t pw [5] = '{'{8'h03, 8'hff, 512, 10'h1e0}, '{8'h01, 8'h40, 256, 10'h040},
    '{8'h41, 8'h40, 256, 10'h040}, '{8'h00, 8'h40, 256, 10'h000}, '{8'h01, 8'hff, 256, 10'h0e0}};
  always #5 pclk = ~pclk;
  bepc_top bepc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .audio_i(audio_i), .audio_vld_i(audio_vld_i), .audio_o(audio_o),
    .audio_vld_o(audio_vld_o), .pwm_o(pwm_o), .pwm_oe(pwm_oe));
  bepc_boost_model bepc_boost_model_inst (.pclk(pclk), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
    .clr(clr), .pin(pin), .hi_cnt(hi_cnt), .drv_hi(drv_hi));
  // Single exit point for verdict and timeouts
  task complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; held until pready is sampled, idle edge after
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin
      err_total++;
      $display("[ERR] %0t apb no ready", $time);
      complete_run();
    end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    // Register table: reset values, clamps, unmapped access
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].q, "read data");
      chk({31'h0, er}, {31'h0, rows[i].e}, "slverr");
    end
    $display("register table done");
    // Duty per format and drive mode, measured over one whole period
    foreach (pw[i]) begin
      apb(1, ADDR_TRIM, {24'h0, pw[i].trim});
      apb(1, ADDR_CTRL, {24'h0, pw[i].ctl});
      repeat (1100) @(posedge pclk);
      clr <= 1;
      @(posedge pclk);
      clr <= 0;
      repeat (pw[i].per) @(posedge pclk);
      #1 chk({22'h0, hi_cnt}, {22'h0, pw[i].hi}, "duty");
      if (pw[i].ctl[CTRL_OD]) chk({22'h0, drv_hi}, 0, "open drain high");
      @(posedge pclk);
      $display("pwm case %0d done", i);
    end
    // Look-ahead of two samples, strobes on every other cycle
    apb(1, ADDR_DELAY, 32'h2);
    for (int k = 1; k <= 6; k++) begin
      audio_i <= 16'(k * 16'h0111); audio_vld_i <= 1;
      @(posedge pclk);
      audio_vld_i <= 0;
      #1 chk({31'h0, audio_vld_o}, 1, "vld out");
      if (k > 2) chk({16'h0, audio_o}, {16'h0, 16'((k - 2) * 16'h0111)}, "delayed");
      @(posedge pclk);
    end
    $display("delay test done");
    // Zero delay passes the sample straight; a smaller one keeps the held peak
    apb(1, ADDR_DELAY, 32'h0);
    audio_i <= 16'h0100;
    audio_vld_i <= 1;
    @(posedge pclk);
    audio_vld_i <= 0;
    #1 chk({16'h0, audio_o}, 32'h100, "no delay");
    @(posedge pclk);
    apb(0, ADDR_STAT, 0);
    chk({17'h0, rd[14:0]}, 32'h666, "peak held");
    chk({28'h0, rd[19:16]}, 32'h7, "top level");
    chk({20'h0, rd[31:21], rd[15]}, 32'h0, "status spare bits");
    $display("peak hold test done");
    // Mid-run reset: pin back to idle pull-low, state back to defaults
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({30'h0, pwm_o, pwm_oe}, 32'h1, "pin after reset");
    chk({15'h0, audio_o, audio_vld_o}, 32'h0, "audio after reset");
    apb(0, ADDR_CTRL, 0);
    chk(rd, {24'h0, CTRL_RST}, "ctrl after reset");
    apb(0, ADDR_STAT, 0);
    chk(rd, 32'h0, "status after reset");
    $display("reset test done");
    complete_run();
  end
endmodule
